// file: design/ccm_defs.svh
// Constant definitions for the CPU clock select and oscillator monitor
`ifndef CCM_DEFS_SVH
`define CCM_DEFS_SVH

// Clock-mode strap codes
`define CCM_STRAP_X4 3'h7
`define CCM_STRAP_X3 3'h6
`define CCM_STRAP_X8 3'h5
`define CCM_STRAP_X5 3'h4
`define CCM_STRAP_DIRECT 3'h3
`define CCM_STRAP_X10 3'h2
`define CCM_STRAP_PRESCALE 3'h1
`define CCM_STRAP_X16 3'h0

// Strap value assumed before the first capture
`define CCM_STRAP_RESET 3'h7

// Position of the monitor disable bit in the system configuration register
`define CCM_OSC_MON_DIS_BIT 4

// Monitor counter width and overflow count (free-running PLL cycles)
`define CCM_MON_CNT_W 5
`define CCM_MON_OVERFLOW 5'h10

// Multiplication factors
`define CCM_F_X1 5'h01
`define CCM_F_X3 5'h03
`define CCM_F_X4 5'h04
`define CCM_F_X5 5'h05
`define CCM_F_X8 5'h08
`define CCM_F_X10 5'h0a
`define CCM_F_X16 5'h10

// Input divider, VCO multiplier and post-VCO divider settings
`define CCM_IN_DIV_4 3'h4
`define CCM_IN_DIV_2 3'h2
`define CCM_IN_DIV_1 3'h1
`define CCM_VCO_MUL_64 7'h40
`define CCM_VCO_MUL_48 7'h30
`define CCM_VCO_MUL_40 7'h28
`define CCM_VCO_MUL_0 7'h00
`define CCM_POST_DIV_4 3'h4
`define CCM_POST_DIV_2 3'h2
`define CCM_POST_DIV_1 3'h1

`endif

// file: design/ccm_pkg.sv
// Types shared by the CPU clock select and oscillator monitor
package ccm_pkg;

  // Source currently feeding the CPU clock tree
  typedef enum logic [1:0]
  {
    CCM_SRC_DIRECT,
    CCM_SRC_PRESCALE,
    CCM_SRC_PLL,
    CCM_SRC_PLL_FREE
  } ccm_src_e;

  typedef logic [2:0] ccm_strap_t;

endpackage

// file: design/ccm_clock_select.sv
// CPU clock mode selection, PLL setup and oscillator-loss monitor
`timescale 1ns/10ps
`include "ccm_defs.svh"

// What this block does
// - Monitor is enabled after reset; system config bit 4 set disables it.
// - Monitor acts only in direct-drive and divide-by-two prescaler modes.
// - Enabled monitor counts free PLL cycles, cleared by each crystal edge.
// - Sixteen free PLL cycles without a crystal edge mean clock failure.
// - On failure switch CPU clock to free PLL and raise loss interrupt.
// - Failure switch holds until the next reset, even if crystal returns.
// - Monitor disabled in codes 011 and 001 with no failure latched: CPU clock from oscillator path, PLL powered off.
// - Other strap codes enable the PLL and multiply by the coded factor; code 000 gets the x10 divider settings.
// - PLL mode resynchronises CPU clock on every F-th crystal transition.
// - PLL path: input divider, VCO multiplier, post divider; output halver only in code 001.
// - Divider settings per strap code, with 011 and 001 bypassing the PLL.
// - Code 011 disables PLL, bypasses amplifier, drives CPU from crystal.
// - Code 001 drives CPU clock from oscillator through a 2:1 prescaler.
// - PLL lock loss raises interrupt, detaches reference until reset.
module ccm_clock_select
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Pins from outside the clock domain
  input wire logic [2:0] clock_mode_straps_i,
  input wire logic crystal_input_pin_i,
  // Same-domain inputs
  input wire logic [15:0] system_config_register_i,
  input wire logic pll_free_tick_i,
  input wire logic pll_locked_i,
  // Clock tree and PLL control
  output ccm_pkg::ccm_src_e cpu_clk_src_o,
  output logic [2:0] clock_mode_o,
  output logic [4:0] mul_factor_o,
  output logic pll_enable_o,
  output logic pll_power_o,
  output logic pll_ref_connect_o,
  output logic osc_amp_bypass_o,
  output logic [2:0] pll_in_div_o,
  output logic [6:0] pll_vco_mul_o,
  output logic [2:0] pll_post_div_o,
  output logic out_div2_o,
  output logic pll_resync_o,
  // Status and events
  output logic osc_monitor_active_o,
  output logic osc_fail_o,
  output logic osc_loss_irq_o,
  output logic pll_unlock_irq_o
);
  import ccm_pkg::*;

  // Multiplication factor for a strap code
  function automatic logic [4:0] factor_of(input ccm_strap_t code);
    logic [4:0] f;
    f = `CCM_F_X1;
    unique case (code)
      `CCM_STRAP_X4: f = `CCM_F_X4;
      `CCM_STRAP_X3: f = `CCM_F_X3;
      `CCM_STRAP_X8: f = `CCM_F_X8;
      `CCM_STRAP_X5: f = `CCM_F_X5;
      `CCM_STRAP_DIRECT: f = `CCM_F_X1;
      `CCM_STRAP_X10: f = `CCM_F_X10;
      `CCM_STRAP_PRESCALE: f = `CCM_F_X1;
      `CCM_STRAP_X16: f = `CCM_F_X16;
    endcase
    return f;
  endfunction

  // True for the two codes that bypass the PLL
  function automatic logic is_bypass(input ccm_strap_t code);
    return (code == `CCM_STRAP_DIRECT) || (code == `CCM_STRAP_PRESCALE);
  endfunction

  // Three-stage synchronisers; a change counts when stages two and three agree
  logic [2:0] strap_s1_r;
  logic [2:0] strap_s2_r;
  logic [2:0] strap_s3_r;
  logic xtal_s1_r;
  logic xtal_s2_r;
  logic xtal_s3_r;
  logic xtal_lvl_r;
  logic xtal_edge;

  always_ff @(posedge clock_i)
  begin
    strap_s1_r <= clock_mode_straps_i;
    strap_s2_r <= strap_s1_r;
    strap_s3_r <= strap_s2_r;
    xtal_s1_r <= crystal_input_pin_i;
    xtal_s2_r <= xtal_s1_r;
    xtal_s3_r <= xtal_s2_r;
  end

  // Reset loads the pin level so no false edge follows the release
  always_ff @(posedge clock_i)
  begin
    if (srst_i || (xtal_s2_r == xtal_s3_r))
      xtal_lvl_r <= xtal_s3_r;
  end

  assign xtal_edge = (xtal_s2_r == xtal_s3_r) && (xtal_s3_r != xtal_lvl_r);

  // Strap capture while reset is held
  ccm_strap_t mode_r;

  always_ff @(posedge clock_i)
  begin
    if (srst_i && (strap_s2_r == strap_s3_r))
      mode_r <= strap_s3_r;
  end

  logic strap_seen_r;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      strap_seen_r <= 1'b0;
    else
      strap_seen_r <= 1'b1;
  end

  ccm_strap_t mode;
  logic bypass;
  logic [4:0] factor;

  assign mode = mode_r;
  assign bypass = is_bypass(mode);
  assign factor = factor_of(mode);

  // Monitor enable from the disable bit of the system configuration register
  logic mon_en_r;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      mon_en_r <= 1'b1;
    else
      mon_en_r <= !system_config_register_i[`CCM_OSC_MON_DIS_BIT];
  end

  logic mon_run;

  assign mon_run = mon_en_r && bypass && strap_seen_r;

  // Monitor counter of free-running PLL cycles
  logic [`CCM_MON_CNT_W-1:0] mon_cnt_r;
  logic osc_fail_r;
  logic fail_set;

  assign fail_set = mon_run && !osc_fail_r && pll_free_tick_i && !xtal_edge &&
    (mon_cnt_r == `CCM_MON_OVERFLOW - 5'h01);

  always_ff @(posedge clock_i)
  begin
    if (srst_i || !mon_run || xtal_edge)
      mon_cnt_r <= '0;
    else if (pll_free_tick_i && !osc_fail_r)
      mon_cnt_r <= mon_cnt_r + 5'h01;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      osc_fail_r <= 1'b0;
    else if (fail_set)
      osc_fail_r <= 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      osc_loss_irq_o <= 1'b0;
    else
      osc_loss_irq_o <= fail_set;
  end

  // Lock loss in PLL mode detaches the reference until reset
  logic unlocked_r;
  logic lock_seen_r;
  logic unlock_set;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      lock_seen_r <= 1'b0;
    else if (!bypass && pll_locked_i)
      lock_seen_r <= 1'b1;
  end

  assign unlock_set = !bypass && lock_seen_r && !pll_locked_i && !unlocked_r;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      unlocked_r <= 1'b0;
    else if (unlock_set)
      unlocked_r <= 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      pll_unlock_irq_o <= 1'b0;
    else
      pll_unlock_irq_o <= unlock_set;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      pll_ref_connect_o <= 1'b1;
    else
      pll_ref_connect_o <= !bypass && !unlocked_r && !unlock_set;
  end

  // Resynchronisation on every F-th crystal transition in PLL mode
  logic [4:0] sync_cnt_r;
  logic sync_hit;

  assign sync_hit = xtal_edge && (sync_cnt_r == factor - 5'h01);

  always_ff @(posedge clock_i)
  begin
    if (srst_i || bypass || unlocked_r)
      sync_cnt_r <= '0;
    else if (sync_hit)
      sync_cnt_r <= '0;
    else if (xtal_edge)
      sync_cnt_r <= sync_cnt_r + 5'h01;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      pll_resync_o <= 1'b0;
    else
      pll_resync_o <= !bypass && !unlocked_r && sync_hit;
  end

  // CPU clock source
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      cpu_clk_src_o <= CCM_SRC_DIRECT;
    else if (osc_fail_r || fail_set)
      cpu_clk_src_o <= CCM_SRC_PLL_FREE;
    else if (!bypass)
      cpu_clk_src_o <= (unlocked_r || unlock_set) ? CCM_SRC_PLL_FREE :
        CCM_SRC_PLL;
    else if (mode == `CCM_STRAP_PRESCALE)
      cpu_clk_src_o <= CCM_SRC_PRESCALE;
    else
      cpu_clk_src_o <= CCM_SRC_DIRECT;
  end

  // PLL power and enable
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      pll_power_o <= 1'b0;
      pll_enable_o <= 1'b0;
    end
    else
    begin
      pll_power_o <= !bypass || mon_en_r || osc_fail_r;
      pll_enable_o <= !bypass;
    end
  end

  // PLL divider settings
  always_ff @(posedge clock_i)
  begin
    pll_in_div_o <= `CCM_IN_DIV_1;
    pll_vco_mul_o <= `CCM_VCO_MUL_0;
    pll_post_div_o <= `CCM_POST_DIV_1;
    out_div2_o <= 1'b0;
    if (!srst_i)
    begin
      unique case (mode)
        `CCM_STRAP_X4:
        begin
          pll_in_div_o <= `CCM_IN_DIV_4;
          pll_vco_mul_o <= `CCM_VCO_MUL_64;
          pll_post_div_o <= `CCM_POST_DIV_4;
        end
        `CCM_STRAP_X3:
        begin
          pll_in_div_o <= `CCM_IN_DIV_4;
          pll_vco_mul_o <= `CCM_VCO_MUL_48;
          pll_post_div_o <= `CCM_POST_DIV_4;
        end
        `CCM_STRAP_X8:
        begin
          pll_in_div_o <= `CCM_IN_DIV_4;
          pll_vco_mul_o <= `CCM_VCO_MUL_64;
          pll_post_div_o <= `CCM_POST_DIV_2;
        end
        `CCM_STRAP_X5:
        begin
          pll_in_div_o <= `CCM_IN_DIV_4;
          pll_vco_mul_o <= `CCM_VCO_MUL_40;
          pll_post_div_o <= `CCM_POST_DIV_2;
        end
        `CCM_STRAP_X10, `CCM_STRAP_X16:
        begin
          pll_in_div_o <= `CCM_IN_DIV_2;
          pll_vco_mul_o <= `CCM_VCO_MUL_40;
          pll_post_div_o <= `CCM_POST_DIV_2;
        end
        `CCM_STRAP_PRESCALE:
          out_div2_o <= 1'b1;
        `CCM_STRAP_DIRECT:
          out_div2_o <= 1'b0;
      endcase
    end
  end

  // Mode, factor and status reporting
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      clock_mode_o <= `CCM_STRAP_RESET;
      mul_factor_o <= `CCM_F_X1;
      osc_amp_bypass_o <= 1'b0;
      osc_monitor_active_o <= 1'b0;
      osc_fail_o <= 1'b0;
    end
    else
    begin
      clock_mode_o <= mode;
      mul_factor_o <= factor;
      osc_amp_bypass_o <= (mode == `CCM_STRAP_DIRECT);
      osc_monitor_active_o <= mon_run && !osc_fail_r;
      osc_fail_o <= osc_fail_r || fail_set;
    end
  end

endmodule

// file: sim/ccm_clock_select_assertions.sv
// Concurrent checks on the clock select ports
`timescale 1ns/10ps
module ccm_clock_select_assertions
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Watched signals
  input wire logic [15:0] system_config_register_i,
  input wire logic pll_free_tick_i,
  input wire ccm_pkg::ccm_src_e cpu_clk_src_o,
  input wire logic [2:0] clock_mode_o,
  input wire logic pll_enable_o,
  input wire logic pll_power_o,
  input wire logic pll_ref_connect_o,
  input wire logic pll_resync_o,
  input wire logic osc_fail_o,
  input wire logic osc_loss_irq_o,
  input wire logic pll_unlock_irq_o
);
  import ccm_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic byp;
  assign byp = (clock_mode_o == 3'h3) || (clock_mode_o == 3'h1);
  a_loss_irq_pulse: assert property (osc_loss_irq_o |=> !osc_loss_irq_o)
    else $error("loss irq longer than one cycle");
  a_fail_switch_src: assert property ($rose(osc_fail_o) |->
    osc_loss_irq_o && cpu_clk_src_o == CCM_SRC_PLL_FREE)
    else $error("failure without irq or clock switch");
  a_fail_stays_set: assert property (osc_fail_o |=> osc_fail_o)
    else $error("failure flag cleared without reset");
  a_free_src_holds: assert property (
    cpu_clk_src_o == CCM_SRC_PLL_FREE |=> cpu_clk_src_o == CCM_SRC_PLL_FREE)
    else $error("clock left free PLL without reset");
  a_fail_bypass_only: assert property (osc_fail_o |-> byp)
    else $error("monitor failure in PLL mode");
  a_loss_after_tick: assert property (osc_loss_irq_o |-> $past(pll_free_tick_i))
    else $error("loss irq without PLL tick");
  a_mode_held: assert property (!$past(srst_i) && !$past(srst_i, 2) |->
    $stable(clock_mode_o))
    else $error("mode changed outside reset");
  a_disabled_pll_off: assert property (
    (byp && system_config_register_i[4] && !osc_fail_o) [*4] |-> !pll_power_o)
    else $error("PLL powered with monitor disabled");
  a_enable_pll_code: assert property (pll_enable_o |-> !byp)
    else $error("PLL enabled in bypass code");
  a_unlock_detach: assert property (pll_unlock_irq_o |->
    !pll_ref_connect_o && cpu_clk_src_o == CCM_SRC_PLL_FREE)
    else $error("unlock without detach");
  a_ref_stays_off: assert property (!pll_ref_connect_o |=> !pll_ref_connect_o)
    else $error("reference reattached without reset");
  a_resync_in_pll: assert property (pll_resync_o |-> pll_enable_o)
    else $error("resync outside PLL mode");
  c_osc_loss: cover property (osc_loss_irq_o);
  c_unlock: cover property (pll_unlock_irq_o);
  c_resync: cover property (pll_resync_o);
endmodule

// file: sim/ccm_xtal_model.sv
// Crystal source and free-running PLL tick model
`timescale 1ns/10ps
module ccm_xtal_model
(
  // Clock
  input wire logic clock_i,
  // Control
  input wire logic run_i,
  // Outputs
  output logic xtal_o,
  output logic tick_o
);
  logic [1:0] div_r = 2'h0;
  logic go;
  initial xtal_o = 1'b0;
  initial tick_o = 1'b0;
  // Slow crystal inside the legal input range, stops dead on failure
  // Run is read on the edge, before the bench moves it
  always @(posedge clock_i)
  begin
    go = run_i && (div_r == 2'h3);
    #1;
    div_r = div_r + 2'h1;
    if (go)
      xtal_o = ~xtal_o;
    tick_o = ~tick_o;
  end
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the clock select block
`timescale 1ns/10ps
`include "ccm_defs.svh"
module tb_top;
  import ccm_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic run = 1'b1;
  logic locked = 1'b0;
  logic [2:0] straps = 3'h3;
  logic [15:0] cfg = 16'h0000;
  logic xtal, tick, pen, ppow, pref, amp, div2, resync, mact, fail, lirq, uirq;
  ccm_src_e src;
  logic [2:0] mode, in_div, post_div;
  logic [4:0] fac;
  logic [6:0] vco;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  always #10 clock_i = ~clock_i;
  ccm_xtal_model u_ccm_xtal_model (.clock_i(clock_i), .run_i(run),
    .xtal_o(xtal), .tick_o(tick));
  ccm_clock_select u_ccm_clock_select (.clock_i(clock_i), .srst_i(srst_i),
    .clock_mode_straps_i(straps), .crystal_input_pin_i(xtal),
    .system_config_register_i(cfg), .pll_free_tick_i(tick),
    .pll_locked_i(locked), .cpu_clk_src_o(src), .clock_mode_o(mode),
    .mul_factor_o(fac), .pll_enable_o(pen), .pll_power_o(ppow),
    .pll_ref_connect_o(pref), .osc_amp_bypass_o(amp), .pll_in_div_o(in_div),
    .pll_vco_mul_o(vco), .pll_post_div_o(post_div), .out_div2_o(div2),
    .pll_resync_o(resync), .osc_monitor_active_o(mact), .osc_fail_o(fail),
    .osc_loss_irq_o(lirq), .pll_unlock_irq_o(uirq));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input string what, input logic [6:0] exp, got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic [2:0] code);
    straps = code;
    srst_i = 1'b1;
    cyc(10);
    srst_i = 1'b0;
    cyc(2);
  endtask
  task automatic t_modes;
    logic [4:0] ft [8] = '{5'h10, 5'h01, 5'h0a, 5'h01, 5'h05, 5'h08, 5'h03,
      5'h04};
    logic [6:0] vt [8] = '{7'h28, 7'h0, 7'h28, 7'h0, 7'h28, 7'h40, 7'h30,
      7'h40};
    logic byp;
    for (int c = 0; c < 8; c++)
    begin
      do_reset(c[2:0]);
      byp = (c == 3) || (c == 1);
      chk("factor", ft[c], fac);
      chk("pll_enable", !byp, pen);
      chk("amp_bypass", c == 3, amp);
      chk("out_div2", c == 1, div2);
      chk("src", byp ? (c == 3 ? CCM_SRC_DIRECT : CCM_SRC_PRESCALE)
        : CCM_SRC_PLL, src);
      if (!byp)
      begin
        chk("vco_mul", vt[c], vco);
        chk("in_div", c[2] ? 3'h4 : 3'h2, in_div);
        chk("post_div", c > 5 ? 3'h4 : 3'h2, post_div);
      end
      straps = ~c[2:0];
      cyc(5);
      chk("mode_held", c, mode);
    end
  endtask
  task automatic t_owd(input logic [2:0] code);
    int i;
    cfg = 16'h0000;
    run = 1'b1;
    do_reset(code);
    cyc(100);
    chk("monitor_on", 1, mact);
    chk("no_fail", 0, fail);
    run = 1'b0;
    for (i = 0; i < 100 && lirq !== 1'b1; i++)
      cyc(1);
    chk("delay_ok", 1, i >= 24 && i <= 40);
    chk("loss_irq", 1, lirq);
    chk("src_free", CCM_SRC_PLL_FREE, src);
    cyc(1);
    chk("irq_pulse", 0, lirq);
    run = 1'b1;
    cyc(50);
    chk("src_stays", CCM_SRC_PLL_FREE, src);
    chk("fail_stays", 1, fail);
  endtask
  task automatic t_pll;
    int n = 0;
    run = 1'b1;
    do_reset(3'h7);
    repeat (100)
    begin
      cyc(1);
      n += resync;
    end
    chk("resync_ok", 1, n >= 5 && n <= 7);
    run = 1'b0;
    cyc(100);
    chk("no_fail_pll", 0, fail);
    chk("src_pll", CCM_SRC_PLL, src);
    locked = 1'b1;
    cyc(5);
    locked = 1'b0;
    cyc(1);
    chk("unlock_irq", 1, uirq);
    chk("ref_off", 0, pref);
    chk("src_free", CCM_SRC_PLL_FREE, src);
  endtask
  task automatic t_disabled;
    cfg = 16'h0010;
    run = 1'b1;
    do_reset(3'h1);
    cyc(3);
    chk("pll_power", 0, ppow);
    run = 1'b0;
    cyc(100);
    chk("no_fail_dis", 0, fail);
    chk("src_osc", CCM_SRC_PRESCALE, src);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial
  begin
    t_modes();
    t_owd(3'h3);
    t_owd(3'h1);
    t_pll();
    t_disabled();
    tally_and_finish();
  end
endmodule
bind ccm_clock_select ccm_clock_select_assertions u_ccm_clock_select_assertions
  (.clock_i(clock_i), .srst_i(srst_i),
  .system_config_register_i(system_config_register_i),
  .pll_free_tick_i(pll_free_tick_i), .cpu_clk_src_o(cpu_clk_src_o),
  .clock_mode_o(clock_mode_o), .pll_enable_o(pll_enable_o),
  .pll_power_o(pll_power_o), .pll_ref_connect_o(pll_ref_connect_o),
  .pll_resync_o(pll_resync_o), .osc_fail_o(osc_fail_o),
  .osc_loss_irq_o(osc_loss_irq_o), .pll_unlock_irq_o(pll_unlock_irq_o));
